// *** pwmas_asserts.sv ***
// Port checker of the PWM auto-shutdown control
`timescale 1ns/1ps
module pwmas_asserts
    import pwmas_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic        o_pready,
    input wire logic [1:0]  i_pwm_ac,
    input wire logic [1:0]  i_pwm_bd,
    input wire logic        i_cmp1,
    input wire logic        i_cmp2,
    input wire logic        i_external_fault_input,
    input wire logic [1:0]  o_pin_ac,
    input wire logic [1:0]  o_pin_ac_oe,
    input wire logic [1:0]  o_pin_bd,
    input wire logic [1:0]  o_pin_bd_oe,
    input wire logic        o_shutdown
);
    // ----
    // Shadow state
    // ----
    logic [6:0] cfg_ff;
    logic [2:0] d1_ff;
    logic [2:0] d2_ff;
    logic       wr_cfg;
    logic       hit;
    // Config write and selected trigger after two-flop delay
    assign wr_cfg = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0]
                    & (i_paddr == ADDR_CONFIG);
    assign hit = (cfg_ff[6:4] != SRC_RSVD) && (|(cfg_ff[6:4] & d2_ff));
    // Copy of source and level fields
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            cfg_ff <= 7'h00;
        else if (wr_cfg)
            cfg_ff <= i_pwdata[6:0];
    end
    // Trigger delay line, order fault, cmp2, cmp1
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            {d2_ff, d1_ff} <= 6'h00;
        else
            {d2_ff, d1_ff} <= {d1_ff, i_external_fault_input, i_cmp2, i_cmp1};
    end
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    chk_ac_normal: assert property (
        !o_shutdown && !$past(i_rst) |-> o_pin_ac_oe == 2'h3
        && o_pin_ac == $past(i_pwm_ac)) else $error("ac not normal");
    chk_bd_normal: assert property (
        !o_shutdown && !$past(i_rst) |-> o_pin_bd_oe == 2'h3
        && o_pin_bd == $past(i_pwm_bd)) else $error("bd not normal");
    chk_ac_level: assert property (
        o_shutdown && !$past(i_rst) |-> (cfg_ff[3] ? {o_pin_ac_oe, o_pin_ac}
        == 4'h0 : {o_pin_ac_oe, o_pin_ac} == {2'h3, {2{cfg_ff[2]}}}))
        else $error("ac bad level");
    chk_bd_level: assert property (
        o_shutdown && !$past(i_rst) |-> (cfg_ff[1] ? {o_pin_bd_oe, o_pin_bd}
        == 4'h0 : {o_pin_bd_oe, o_pin_bd} == {2'h3, {2{cfg_ff[0]}}}))
        else $error("bd bad level");
    chk_event_sets: assert property (
        hit |=> o_shutdown) else $error("event missed");
    chk_no_spurious: assert property (
        !hit && !wr_cfg && !o_shutdown |=> !o_shutdown)
        else $error("spurious shutdown");
    chk_flag_sticky: assert property (
        o_shutdown && !wr_cfg |=> o_shutdown) else $error("flag lost");
    chk_sw_set: assert property (
        wr_cfg && i_pwdata[7] |=> cfg_ff == $past(i_pwdata[6:0])
        && o_shutdown)
        else $error("flag not set");
    cover property (hit && cfg_ff[6]);
    cover property (o_shutdown && cfg_ff[3] && cfg_ff[1]);
    cover property ($fell(o_shutdown));
endmodule
bind pwmas_top pwmas_asserts chk_u (.*);

// *** pwmas_pkg.sv ***
// Package: register map, field layout and types of the PWM auto-shutdown block
package pwmas_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CONFIG    = 12'h000;
    localparam logic [11:0] ADDR_IRQ_STAT  = 12'h004;
    localparam logic [11:0] ADDR_IRQ_MASK  = 12'h008;
    localparam logic [11:0] ADDR_PWM_IN    = 12'h00c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          FLAG_BIT       = 7;
    localparam int          SRC_HI         = 6;
    localparam int          SRC_LO         = 4;
    localparam int          AC_HI          = 3;
    localparam int          AC_LO          = 2;
    localparam int          BD_HI          = 1;
    localparam int          BD_LO          = 0;
    localparam logic [7:0]  CONFIG_RST     = 8'h00;
    localparam logic [1:0]  IRQ_RST        = 2'h0;
    localparam int          IRQ_SHUT_BIT   = 0;
    localparam int          IRQ_REL_BIT    = 1;

    // Shutdown source select codes
    localparam logic [2:0]  SRC_OFF        = 3'h0;
    localparam logic [2:0]  SRC_CMP1       = 3'h1;
    localparam logic [2:0]  SRC_CMP2       = 3'h2;
    localparam logic [2:0]  SRC_CMP_ANY    = 3'h3;
    localparam logic [2:0]  SRC_FAULT      = 3'h4;
    localparam logic [2:0]  SRC_FAULT_C1   = 3'h5;
    localparam logic [2:0]  SRC_FAULT_C2   = 3'h6;
    localparam logic [2:0]  SRC_RSVD       = 3'h7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PWMAS_LVL_LOW  = 2'b00,
        PWMAS_LVL_HIGH = 2'b01,
        PWMAS_LVL_TRI  = 2'b10
    } pwmas_lvl_t;

    // One pin pair: value and output enable
    typedef struct packed
    {
        logic [1:0] val;
        logic [1:0] oe;
    } pwmas_pair_t;

    // Trigger inputs
    typedef struct packed
    {
        logic cmp1;
        logic cmp2;
        logic fault;
    } pwmas_trig_t;

endpackage

// *** pwmas_top.sv ***
// PWM auto-shutdown control with APB register access
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Set flag bit 7 on selected shutdown event; force outputs; normal when zero
// - Source select bits 6..4; code 000 disables the shutdown events, but a write of 1 to bit 7 still forces shutdown
// - 001 comparator 1, 010 comparator 2, 011 either comparator
// - 100 fault input, 101 fault or comparator 1, 110 fault or comparator 2
// - Bits 3..2 set pins A,C in shutdown: 00 low, 01 high, 1x tri-state
// - Bits 1..0 set pins B,D in shutdown: 00 low, 01 high, 1x tri-state
module pwmas_top
    import pwmas_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [1:0]  i_pwm_ac,
    input  wire logic [1:0]  i_pwm_bd,
    input  wire logic        i_cmp1,
    input  wire logic        i_cmp2,
    input  wire logic        i_external_fault_input,
    output logic      [1:0]  o_pin_ac,
    output logic      [1:0]  o_pin_ac_oe,
    output logic      [1:0]  o_pin_bd,
    output logic      [1:0]  o_pin_bd_oe,
    output logic             o_shutdown,
    output logic             o_irq
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Trigger selected by a source code
    function automatic logic sel_trig(input logic [2:0] src,
                                      input pwmas_trig_t t);
        logic r;
        r = 1'b0;
        case (src)
            SRC_CMP1:     r = t.cmp1;
            SRC_CMP2:     r = t.cmp2;
            SRC_CMP_ANY:  r = t.cmp1 | t.cmp2;
            SRC_FAULT:    r = t.fault;
            SRC_FAULT_C1: r = t.fault | t.cmp1;
            SRC_FAULT_C2: r = t.fault | t.cmp2;
            SRC_OFF:      r = 1'b0;
            SRC_RSVD:     r = 1'b0;
            default:      r = 1'b0;
        endcase
        return r;
    endfunction

    // Pin pair levels: normal PWM or shutdown state
    function automatic pwmas_pair_t pair_out(input logic       shut,
                                             input logic [1:0] lvl,
                                             input logic [1:0] pwm);
        pwmas_pair_t p;
        p.val = pwm;
        p.oe  = 2'b11;
        if (shut)
        begin
            if (lvl[1])
            begin
                p.val = 2'b00;
                p.oe  = 2'b00;                        // Tri-state
            end
            else if (lvl == PWMAS_LVL_HIGH)
                p.val = 2'b11;
            else
                p.val = 2'b00;
        end
        return p;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0]  trig_s1_ff;
    logic [2:0]  trig_s2_ff;
    pwmas_trig_t trig;

    // Two flops on each external trigger
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            trig_s1_ff <= 3'h0;
            trig_s2_ff <= 3'h0;
        end
        else
        begin
            trig_s1_ff <= {i_cmp1, i_cmp2, i_external_fault_input};
            trig_s2_ff <= trig_s1_ff;
        end
    end

    assign trig = pwmas_trig_t'(trig_s2_ff);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  config_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic        wr_en;
    logic        rd_en;
    logic        event_hit;
    logic        flag_clr;
    logic        flag_set_edge;
    logic [7:0]  nxt_config;
    logic [1:0]  nxt_irq_stat;
    logic [31:0] nxt_prdata;
    logic        addr_ok;

    // Access phase of APB, single-cycle answer
    assign wr_en = i_psel & i_penable & i_pwrite & o_pready;
    assign rd_en = i_psel & i_penable & ~i_pwrite & o_pready;

    assign event_hit = sel_trig(config_ff[SRC_HI:SRC_LO], trig);

    // Software writing 0 to the flag clears it unless a selected event is active in the same cycle
    assign flag_clr = wr_en && (i_paddr == ADDR_CONFIG) && i_pstrb[0]
                      && !i_pwdata[FLAG_BIT];

    assign flag_set_edge = event_hit & ~config_ff[FLAG_BIT];

    // Config register: fields written by software, flag set by events
    always_comb
    begin
        nxt_config = config_ff;
        if (wr_en && (i_paddr == ADDR_CONFIG) && i_pstrb[0])
            nxt_config = i_pwdata[7:0];
        if (event_hit)
            nxt_config[FLAG_BIT] = 1'b1;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            config_ff <= CONFIG_RST;
        else
            config_ff <= nxt_config;
    end

    // Sticky interrupt status: set wins over write-one-to-clear
    always_comb
    begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_en && (i_paddr == ADDR_IRQ_STAT) && i_pstrb[0])
            nxt_irq_stat = irq_stat_ff & ~i_pwdata[1:0];
        if (flag_set_edge)
            nxt_irq_stat[IRQ_SHUT_BIT] = 1'b1;
        if (flag_clr && config_ff[FLAG_BIT] && !event_hit)
            nxt_irq_stat[IRQ_REL_BIT] = 1'b1;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            irq_stat_ff <= IRQ_RST;
        else
            irq_stat_ff <= nxt_irq_stat;
    end

    // Interrupt mask
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            irq_mask_ff <= IRQ_RST;
        else if (wr_en && (i_paddr == ADDR_IRQ_MASK) && i_pstrb[0])
            irq_mask_ff <= i_pwdata[1:0];
    end

    // ------------------------------------------------------------
    // APB slave answer
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_prdata = 32'h0;
        addr_ok    = 1'b1;
        case (i_paddr)
            ADDR_CONFIG:   nxt_prdata = {24'h0, config_ff};
            ADDR_IRQ_STAT: nxt_prdata = {30'h0, irq_stat_ff};
            ADDR_IRQ_MASK: nxt_prdata = {30'h0, irq_mask_ff};
            ADDR_PWM_IN:   nxt_prdata = {28'h0, i_pwm_ac, i_pwm_bd};
            default:       addr_ok    = 1'b0;
        endcase
    end

    // Ready high from the first clock after reset, low during reset: zero wait states
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_pready <= 1'b0;
        else
            o_pready <= 1'b1;
    end

    // Read data and error registered in the setup cycle
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_prdata  <= 32'h0;
            o_pslverr <= 1'b0;
        end
        else if (i_psel && !i_penable)
        begin
            o_prdata  <= i_pwrite ? 32'h0 : nxt_prdata;
            o_pslverr <= ~addr_ok;
        end
        else if (rd_en || wr_en)
        begin
            o_prdata  <= 32'h0;
            o_pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    pwmas_pair_t ac;
    pwmas_pair_t bd;

    // Shutdown follows the flag; normal PWM while it is zero
    assign ac = pair_out(nxt_config[FLAG_BIT],
                         nxt_config[AC_HI:AC_LO], i_pwm_ac);
    assign bd = pair_out(nxt_config[FLAG_BIT],
                         nxt_config[BD_HI:BD_LO], i_pwm_bd);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pin_ac    <= 2'h0;
            o_pin_ac_oe <= 2'h0;
            o_pin_bd    <= 2'h0;
            o_pin_bd_oe <= 2'h0;
            o_shutdown  <= 1'b0;
        end
        else
        begin
            o_pin_ac    <= ac.val;
            o_pin_ac_oe <= ac.oe;
            o_pin_bd    <= bd.val;
            o_pin_bd_oe <= bd.oe;
            o_shutdown  <= nxt_config[FLAG_BIT];
        end
    end

    // Level interrupt from unmasked sticky status
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_irq <= 1'b0;
        else
            o_irq <= |(nxt_irq_stat & irq_mask_ff);
    end

endmodule

// *** pwmas_trig_model.sv ***
// Model of the comparators and the external fault pin
`timescale 1ns/1ps
module pwmas_trig_model
    import pwmas_pkg::*;
(
    input  wire logic  i_core_clk,
    input  wire logic  i_slow,
    input  pwmas_trig_t i_req,
    output pwmas_trig_t o_trig
);
    pwmas_trig_t hold_ff;
    // Slow mode answers one cycle late, like a sluggish comparator
    always_ff @(posedge i_core_clk)
    begin
        hold_ff <= i_req;
        o_trig  <= i_slow ? hold_ff : i_req;
    end
endmodule

// *** tb.sv ***
// Self-checking testbench of the PWM auto-shutdown control
`timescale 1ns/1ps
module tb
    import pwmas_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [1:0]  pwm_ac = 2'h0;
    logic [1:0]  pwm_bd = 2'h0;
    pwmas_trig_t req = '0;
    pwmas_trig_t trig;
    logic [31:0] prdata;
    logic [1:0]  ac, ac_oe, bd, bd_oe;
    logic        pready, pslverr, shut, irq;
    logic [32:0] expq[$];
    int          miscompares = 0;
    int          n_compared = 0;
    // Clock and design
    always #4 clk = ~clk;
    pwmas_top dut_u (.i_core_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_pwm_ac(pwm_ac),
        .i_pwm_bd(pwm_bd), .i_cmp1(trig.cmp1), .i_cmp2(trig.cmp2),
        .i_external_fault_input(trig.fault), .o_pin_ac(ac),
        .o_pin_ac_oe(ac_oe), .o_pin_bd(bd), .o_pin_bd_oe(bd_oe),
        .o_shutdown(shut), .o_irq(irq));
    pwmas_trig_model far_u (.i_core_clk(clk), .i_slow(slow), .i_req(req),
        .o_trig(trig));
    // Compare and verdict
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Expected {oe, value} of one pin pair: normal or shutdown level
    function automatic logic [3:0] pins(input logic s, input logic [1:0] l,
                                        input logic [1:0] p);
        if (!s)
            return {2'h3, p};
        return l[1] ? 4'h0 : {2'h3, {2{l[0]}}};
    endfunction
    // One APB transfer; reads note their expected answer
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        @(posedge clk);
        if (!w)
            expq.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'h1;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            miscompares++;
            give_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read result watcher
    always @(posedge clk)
        if (psel && penable && pready && !pwrite && expq.size() > 0)
            chk({pslverr, prdata}, expq.pop_front());
    // One source code against one trigger, {fault, cmp2, cmp1}
    task automatic one_case(input logic [2:0] src, input logic [2:0] t1);
        logic [3:0] lvl;
        logic       hit;
        lvl = 4'($urandom);
        hit = (src != SRC_RSVD) && (|(src & t1));
        pwm_ac <= 2'($urandom);
        pwm_bd <= 2'($urandom);
        slow <= 1'($urandom);
        apb(1'b1, ADDR_CONFIG, {25'h0, src, lvl}, 33'h0);
        req <= {t1[0], t1[1], t1[2]};
        repeat (6) @(posedge clk);
        apb(1'b0, ADDR_CONFIG, 32'h0, {25'h0, hit, src, lvl});
        chk(33'(irq), 33'(hit));
        chk(33'(shut), 33'(hit));
        chk(33'({ac_oe, ac}), 33'(pins(hit, lvl[3:2], pwm_ac)));
        chk(33'({bd_oe, bd}), 33'(pins(hit, lvl[1:0], pwm_bd)));
        apb(1'b0, ADDR_PWM_IN, 32'h0, {29'h0, pwm_ac, pwm_bd});
        req <= '0;
        repeat (6) @(posedge clk);
        apb(1'b1, ADDR_CONFIG, {25'h0, src, lvl}, 33'h0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0, {31'h0, hit, hit});
        apb(1'b1, ADDR_IRQ_STAT, 32'h3, 33'h0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0, 33'h0);
        chk(33'(irq), 33'h0);
        chk(33'({shut, ac_oe, ac, bd_oe, bd}),
            {24'h0, 1'b0, 2'h3, pwm_ac, 2'h3, pwm_bd});
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(27709));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, ADDR_CONFIG, 32'h0, {25'h0, CONFIG_RST});
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        apb(1'b1, ADDR_IRQ_MASK, 32'h1, 33'h0);
        for (int s = 0; s < 8; s++)
            for (int t = 0; t < 3; t++)
                one_case(3'(s), 3'(1 << t));
        apb(1'b1, ADDR_IRQ_MASK, 32'h0, 33'h0);
        apb(1'b1, ADDR_CONFIG, 32'hcb, 33'h0);
        req <= 3'h1;
        repeat (6) @(posedge clk);
        apb(1'b1, ADDR_CONFIG, 32'h4b, 33'h0);
        apb(1'b0, ADDR_CONFIG, 32'h0, 33'h0cb);
        chk(33'(irq), 33'h0);
        req <= '0;
        repeat (6) @(posedge clk);
        apb(1'b1, ADDR_CONFIG, 32'h4b, 33'h0);
        apb(1'b0, ADDR_CONFIG, 32'h0, 33'h04b);
        give_verdict();
    end
    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule
